// ===== rtl/iltc_params.svh
// Purpose: Offsets, reset values and timing counts of the line transceiver controller
// Assumes: 40 MHz core clock
// Notes: Included by the controller
`ifndef ILTC_PARAMS_SVH
`define ILTC_PARAMS_SVH

`define ILTC_CLK_PERIOD_NS 25
`define ILTC_COMM_TIMEOUT_NS 1200
`define ILTC_STARTUP_NS 1200
// Longest wait rounds down, least wait rounds up
`define ILTC_COMM_TIMEOUT_CYC ((`ILTC_COMM_TIMEOUT_NS) / (`ILTC_CLK_PERIOD_NS))
`define ILTC_STARTUP_CYC (((`ILTC_STARTUP_NS) + (`ILTC_CLK_PERIOD_NS) - 1) / (`ILTC_CLK_PERIOD_NS))
`define ILTC_CNT_W 7
// Idle pin levels: receiver enable released high, slew select floating high
`define ILTC_PIN_IDLE 11'h110

`define ILTC_ADDR_CTRL 4'h0
`define ILTC_ADDR_STATUS 4'h4
`define ILTC_CTRL_ALLOW_BIT 0
`define ILTC_CTRL_RESET 32'h0000_0001

`define ILTC_ST_FAULT_BIT 0
`define ILTC_ST_UVL_BIT 1
`define ILTC_ST_UVI_BIT 2
`define ILTC_ST_OT_BIT 3
`define ILTC_ST_COMM_BIT 4
`define ILTC_ST_DRV_BIT 5
`define ILTC_ST_RX_BIT 6
`define ILTC_ST_FAST_BIT 7
`define ILTC_ST_STATE_LSB 8

`endif

// ===== rtl/iltc_pkg.sv
// Purpose: Types shared by the line transceiver controller
// Assumes: Nothing beyond the params header
// Notes: Pin group travels as one packed struct
package iltc_pkg;

	// Raw pin levels; floating inputs arrive already resolved
	typedef struct packed {
		logic drive_enable;
		logic tx_bit_in;
		logic rx_enable_n;
		logic rx_above_upper;
		logic rx_below_lower;
		logic rx_open_short;
		logic slew_select;
		logic uv_logic_supply;
		logic uv_iso_supply;
		logic over_temp;
		logic barrier_beat;
	} iltc_pins_t;

	typedef enum logic [2:0] {
		ILTC_FAULT = 3'h1,
		ILTC_START = 3'h2,
		ILTC_RUN = 3'h4
	} iltc_state_t;

endpackage : iltc_pkg

// ===== rtl/iltc_sync.sv
// Purpose: Two-flop synchroniser bank for asynchronous pins
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module iltc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : iltc_sync

// ===== rtl/iltc_ctrl.sv
// Purpose: Control and fault logic of an isolated full-duplex line transceiver
// Assumes: Pins are asynchronous and pass the synchroniser; Avalon-MM slave for software
// Notes: Analog thresholds arrive as comparator flags; weak pin drive is a flag output
`timescale 1ns/1ps
`include "iltc_params.svh"
module iltc_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire iltc_pkg::iltc_pins_t pins,
	output logic line_y,
	output logic line_z,
	output logic line_oe,
	output logic logic_side_rx_out,
	output logic logic_side_rx_oe,
	output logic iso_side_rx_out,
	output logic slew_fast,
	output logic fault_pull_up,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	localparam logic [`ILTC_CNT_W-1:0] TIMEOUT_CYC = `ILTC_CNT_W'(`ILTC_COMM_TIMEOUT_CYC);
	localparam logic [`ILTC_CNT_W-1:0] STARTUP_CYC = `ILTC_CNT_W'(`ILTC_STARTUP_CYC);

	// Synchroniser starts at idle pin levels so no false change follows reset
	// sampled crossing
	iltc_pkg::iltc_pins_t s;
	iltc_sync #(
		.W($bits(iltc_pkg::iltc_pins_t)),
		.RST_VAL(`ILTC_PIN_IDLE)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.async_in(pins),
		.sync_out(s)
	);

	// Barrier watchdog and fault sequencer
	logic beat_prev_q, beat_prev_d;
	logic [`ILTC_CNT_W-1:0] wdog_q, wdog_d;
	logic comm_fault_q, comm_fault_d;
	logic [`ILTC_CNT_W-1:0] start_cnt_q, start_cnt_d;
	iltc_pkg::iltc_state_t state_q, state_d;
	logic supply_fault;
	logic fault_src;

	always_comb begin
		beat_prev_d = s.barrier_beat;
		supply_fault = s.uv_logic_supply | s.uv_iso_supply | s.over_temp;
		wdog_d = wdog_q;
		// Link is shut down under supply or thermal faults, so silence then is not a link fault
		if (supply_fault || (s.barrier_beat ^ beat_prev_q)) begin
			wdog_d = '0;
		end else if (wdog_q != TIMEOUT_CYC) begin
			wdog_d = wdog_q + `ILTC_CNT_W'(1);
		end
		comm_fault_d = (wdog_d == TIMEOUT_CYC);
		fault_src = supply_fault | comm_fault_q;
		state_d = state_q;
		start_cnt_d = start_cnt_q;
		case (state_q)
			iltc_pkg::ILTC_FAULT: begin
				start_cnt_d = '0;
				if (!fault_src) begin
					state_d = iltc_pkg::ILTC_START;
				end
			end
			iltc_pkg::ILTC_START: begin
				if (fault_src) begin
					state_d = iltc_pkg::ILTC_FAULT;
				end else if (start_cnt_q == STARTUP_CYC - `ILTC_CNT_W'(1)) begin
					state_d = iltc_pkg::ILTC_RUN;
				end else begin
					start_cnt_d = start_cnt_q + `ILTC_CNT_W'(1);
				end
			end
			iltc_pkg::ILTC_RUN: begin
				if (fault_src) begin
					state_d = iltc_pkg::ILTC_FAULT;
				end
			end
			default: begin
				state_d = iltc_pkg::ILTC_FAULT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			beat_prev_q <= 1'b0;
			wdog_q <= '0;
			comm_fault_q <= 1'b0;
			start_cnt_q <= '0;
			state_q <= iltc_pkg::ILTC_FAULT;
		end else begin
			beat_prev_q <= beat_prev_d;
			wdog_q <= wdog_d;
			comm_fault_q <= comm_fault_d;
			start_cnt_q <= start_cnt_d;
			state_q <= state_d;
		end
	end

	// Register bus
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic [31:0] status;

	// Pin outputs
	logic y_q, y_d, z_q, z_d, oe_q, oe_d;
	logic lrx_q, lrx_d, lrx_oe_q, lrx_oe_d;
	logic irx_q, irx_d, fast_q, fast_d, pull_q, pull_d;
	logic rx_val;
	logic drv_on;
	logic fault_ind;

	always_comb begin
		fault_ind = (state_d != iltc_pkg::ILTC_RUN);
		drv_on = s.drive_enable & ~fault_ind & ctrl_q[`ILTC_CTRL_ALLOW_BIT];
		oe_d = drv_on;
		y_d = drv_on & s.tx_bit_in;
		z_d = drv_on & ~s.tx_bit_in;
		if (s.rx_open_short || s.rx_above_upper) begin
			rx_val = 1'b1;
		end else if (s.rx_below_lower) begin
			rx_val = 1'b0;
		end else begin
			rx_val = irx_q;
		end
		irx_d = rx_val;
		lrx_d = fault_ind | rx_val;
		lrx_oe_d = ~s.rx_enable_n;
		fast_d = s.slew_select;
		pull_d = fault_ind;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			y_q <= 1'b0;
			z_q <= 1'b0;
			oe_q <= 1'b0;
			lrx_q <= 1'b1;
			lrx_oe_q <= 1'b0;
			irx_q <= 1'b1;
			fast_q <= 1'b1;
			pull_q <= 1'b1;
		end else begin
			y_q <= y_d;
			z_q <= z_d;
			oe_q <= oe_d;
			lrx_q <= lrx_d;
			lrx_oe_q <= lrx_oe_d;
			irx_q <= irx_d;
			fast_q <= fast_d;
			pull_q <= pull_d;
		end
	end

	always_comb begin
		status = '0;
		status[`ILTC_ST_FAULT_BIT] = pull_q;
		status[`ILTC_ST_UVL_BIT] = s.uv_logic_supply;
		status[`ILTC_ST_UVI_BIT] = s.uv_iso_supply;
		status[`ILTC_ST_OT_BIT] = s.over_temp;
		status[`ILTC_ST_COMM_BIT] = comm_fault_q;
		status[`ILTC_ST_DRV_BIT] = oe_q;
		status[`ILTC_ST_RX_BIT] = irx_q;
		status[`ILTC_ST_FAST_BIT] = fast_q;
		status[`ILTC_ST_STATE_LSB +: 3] = state_q;
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		wait_d = 1'b1;
		// First request cycle: present data; second: commit write and release
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
			rdata_d = '0;
			if (avs_read && avs_address == `ILTC_ADDR_CTRL) begin
				rdata_d = ctrl_q;
			end else if (avs_read && avs_address == `ILTC_ADDR_STATUS) begin
				rdata_d = status;
			end
		end else if (avs_write && !wait_q && avs_address == `ILTC_ADDR_CTRL) begin
			if (avs_byteenable[0]) begin
				ctrl_d[0] = avs_writedata[0];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `ILTC_CTRL_RESET;
			rdata_q <= '0;
			wait_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
		end
	end

	assign line_y = y_q;
	assign line_z = z_q;
	assign line_oe = oe_q;
	assign logic_side_rx_out = lrx_q;
	assign logic_side_rx_oe = lrx_oe_q;
	assign iso_side_rx_out = irx_q;
	assign slew_fast = fast_q;
	assign fault_pull_up = pull_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	drive_follows_a: assert property (line_oe |-> (line_y == $past(s.tx_bit_in)) && (line_z != line_y))
		else $error("driver outputs do not follow tx bit");
	enable_low_a: assert property (!$past(s.drive_enable) |-> !line_oe && !line_y && !line_z)
		else $error("driver on while enable low");
	thermal_off_a: assert property ($past(s.over_temp) |-> !line_oe)
		else $error("driver on during over-temperature");
	fault_off_a: assert property (fault_pull_up |-> !line_oe)
		else $error("driver on during fault");
	rx_oe_a: assert property (logic_side_rx_oe == !$past(s.rx_enable_n))
		else $error("receiver output enable wrong");
	fail_safe_a: assert property ($past(s.rx_open_short) |-> iso_side_rx_out && logic_side_rx_out)
		else $error("fail-safe not high");
	threshold_low_a: assert property ($past(s.rx_below_lower && !s.rx_open_short && !s.rx_above_upper)
		|-> !iso_side_rx_out)
		else $error("receiver not low below threshold");
	fault_rx_high_a: assert property (fault_pull_up |-> logic_side_rx_out)
		else $error("receiver not forced high in fault");
	uv_fault_a: assert property ($past(s.uv_logic_supply || s.uv_iso_supply) |-> fault_pull_up)
		else $error("undervoltage not flagged");
	silence_fault_a: assert property ($stable(s.barrier_beat) [*8]
		##0 (wdog_q == TIMEOUT_CYC && !supply_fault) |-> ##1 comm_fault_q)
		else $error("barrier silence not flagged");
	restart_a: assert property ($fell(comm_fault_q) && !supply_fault && !comm_fault_q
		|-> ##[1:50] (state_q == iltc_pkg::ILTC_RUN) || fault_src)
		else $error("restart took too long");
	slew_a: assert property (slew_fast == $past(s.slew_select))
		else $error("slew select not applied");
	pull_a: assert property (fault_pull_up == (state_q != iltc_pkg::ILTC_RUN))
		else $error("weak pull direction wrong");
	threshold_high_a: assert property ($past(s.rx_above_upper) |-> iso_side_rx_out)
		else $error("receiver not high above threshold");
	comm_fault_a: assert property ($past(comm_fault_q) |-> fault_pull_up)
		else $error("barrier fault not flagged");
	drive_on_a: assert property ($past(s.drive_enable && ctrl_q[`ILTC_CTRL_ALLOW_BIT])
		&& !fault_pull_up |-> line_oe)
		else $error("driver off while enabled");

	run_drive_c: cover property (state_q == iltc_pkg::ILTC_RUN && line_oe);
	comm_fault_c: cover property ($rose(comm_fault_q));
	restart_c: cover property (state_q == iltc_pkg::ILTC_START ##1 state_q == iltc_pkg::ILTC_RUN);
	bus_write_c: cover property (avs_write && !avs_waitrequest);
	fault_entry_c: cover property ($rose(fault_pull_up));

endmodule : iltc_ctrl

// ===== verification/iltc_mcu_model.sv
// Purpose: Logic-side controller on the receiver-enable/fault pin
// Assumes: Weak device drive behaves like a pull on the wire
// Notes: Strong drive always wins over the weak pull
`timescale 1ns/1ps
module iltc_mcu_model (
	input wire logic drv_on,
	input wire logic drv_level,
	input wire logic fault_pull_up,
	output logic rx_enable_n
);
	assign rx_enable_n = drv_on ? drv_level : fault_pull_up;
endmodule : iltc_mcu_model

// ===== verification/iltc_ctrl_tb.sv
// Purpose: Self-checking bench for the line transceiver controller
// Assumes: 40 MHz clock; partner model on the receiver-enable pin
// Notes: Reset values first, then bus cases, table rows, fault, silence and reset cases
`timescale 1ns/1ps
module iltc_ctrl_tb;
	logic clk, nrst, beat, beat_on, mcu_on, mcu_lvl, re_w;
	logic line_y, line_z, line_oe, rx_out, rx_oe, iso_out, fast, pull_up;
	logic avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [6:0] obs;
	logic [7:0] rst_vec;
	iltc_pkg::iltc_pins_t pin_d, pins_c;
	int err_count, compares;
	// Inputs {de,tx,ren,up,lo,os,slo} beside {oe,y,z,rx_oe,rx,iso,fast}
	logic [13:0] rows [5] = '{14'h34ef, 14'h2258, 14'h1a81, 14'h3be3, 14'h030e};

	assign pins_c = {pin_d[10:9], re_w, pin_d[7:1], beat};
	assign obs = {line_oe, line_y, line_z, rx_oe, rx_oe & rx_out, iso_out, fast};
	assign rst_vec = {line_oe, line_y, line_z, rx_oe, iso_out, fast, pull_up, avs_waitrequest};

	iltc_ctrl dut_u (.clk(clk), .nrst(nrst), .pins(pins_c), .line_y(line_y), .line_z(line_z),
		.line_oe(line_oe), .logic_side_rx_out(rx_out), .logic_side_rx_oe(rx_oe),
		.iso_side_rx_out(iso_out), .slew_fast(fast), .fault_pull_up(pull_up),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	iltc_mcu_model mcu_u (.drv_on(mcu_on), .drv_level(mcu_lvl), .fault_pull_up(pull_up),
		.rx_enable_n(re_w));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Barrier heartbeat toggles while the link is alive
	always @(posedge clk) beat <= beat_on ? ~beat : beat;

	task give_verdict;
		$display("Counts: compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task apply(input logic [6:0] v);
		@(posedge clk);
		pin_d[10:4] <= v;
		mcu_lvl <= v[4];
	endtask : apply

	// Request held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50)
			err_count++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	initial begin
		nrst = 1'b0;
		beat = 1'b0;
		beat_on = 1'b1;
		mcu_on = 1'b1;
		mcu_lvl = 1'b0;
		pin_d = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		err_count = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(rst_vec, 8'h0f);
		@(posedge clk);
		nrst <= 1'b1;
		settle(70);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk({q[10:8], q[0]}, 4'h8);
		bus(1'b1, 4'h8, 32'hffff_ffff);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		$display("test bus done");
		for (int i = 0; i < 5; i++) begin
			apply(rows[i][13:7]);
			settle(4);
			chk(obs, rows[i][6:0]);
		end
		$display("test table done");
		apply(7'h69);
		bus(1'b1, 4'h0, 32'h0);
		settle(4);
		chk(line_oe, 1'b0);
		bus(1'b1, 4'h0, 32'h1);
		settle(4);
		chk(line_oe, 1'b1);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			pin_d[3-k] <= 1'b1;
			settle(4);
			chk({pull_up, line_oe, rx_oe, rx_out}, 4'hb);
			bus(1'b0, 4'h4, 32'h0);
			chk(q[4:0], 5'h1 | (5'h2 << k));
			@(posedge clk);
			mcu_on <= 1'b0;
			settle(4);
			chk({re_w, rx_oe}, 2'h2);
			@(posedge clk);
			mcu_on <= 1'b1;
			pin_d[3-k] <= 1'b0;
			settle(70);
			chk({pull_up, line_oe}, 2'h1);
		end
		$display("test fault done");
		@(posedge clk);
		mcu_on <= 1'b0;
		settle(4);
		chk({re_w, rx_oe}, 2'h1);
		@(posedge clk);
		mcu_on <= 1'b1;
		beat_on <= 1'b0;
		settle(40);
		chk(pull_up, 1'b0);
		settle(16);
		chk({pull_up, line_oe}, 2'h2);
		bus(1'b0, 4'h4, 32'h0);
		chk({q[4], q[0]}, 2'h3);
		@(posedge clk);
		beat_on <= 1'b1;
		settle(70);
		chk(pull_up, 1'b0);
		$display("test barrier done");
		@(posedge clk);
		nrst <= 1'b0;
		@(negedge clk);
		chk(rst_vec, 8'h0f);
		@(posedge clk);
		nrst <= 1'b1;
		settle(70);
		chk({pull_up, line_oe}, 2'h1);
		$display("test reset done");
		give_verdict();
	end
endmodule : iltc_ctrl_tb
